// ---- verilog/sram_write_host.sv ----
`timescale 1ns/100ps
module sram_write_host (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// write request
	input wire logic req_valid,
	input wire sram_wr_pkg::wr_req_s req,
	output logic req_ready,
	output logic wr_done,
	// low-power retention request
	input wire logic retain,
	output logic retaining,
	// memory pins
	output logic [sram_wr_pkg::addr_w-1:0] mem_addr,
	output sram_wr_pkg::strobes_s mem_strobes,
	output logic [sram_wr_pkg::data_w-1:0] mem_data_out,
	output logic mem_data_oe
);
	import sram_wr_pkg::*;

	// an empty lane mask asks for no byte at all
	function automatic logic lanes_empty(input logic [1:0] lanes);
		return ~|lanes;
	endfunction

	wr_state_e state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	wr_req_s req_reg, req_next;
	strobes_s strb_reg, strb_next;
	logic oe_reg, oe_next;
	logic rdy_reg, rdy_next;
	logic done_reg, done_next;
	logic ret_reg, ret_next;

	localparam strobes_s idle_strobes = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		req_next = req_reg;
		strb_next = strb_reg;
		oe_next = oe_reg;
		rdy_next = 1'b0;
		done_next = 1'b0;
		ret_next = ret_reg;
		case (state_reg)
			st_idle: begin
				strb_next = idle_strobes; // R9
				oe_next = 1'b0;
				ret_next = retain;
				if (retain) begin
					// all inputs parked at the select's inactive level
					req_next = '1; // R12
				end else if (req_valid && rdy_reg) begin
					req_next = req;
					state_next = st_float;
					// memory may still drive read data: output enable is high, wait off time
					cnt_next = 4'(oe_off_cyc); // R5 R6
				end else begin
					rdy_next = 1'b1;
				end
			end
			st_float: begin
				if (cnt_reg <= 4'd1 && lanes_empty(req_reg.lanes)) begin
					// nothing selected: a strobe pulse would write nothing, so skip it
					done_next = 1'b1; // R2
					cnt_next = 4'(recover_cyc);
					state_next = st_recover;
				end else if (cnt_reg <= 4'd1) begin
					// all three strobes fall together, lanes from the request
					strb_next.chip_sel_n = 1'b0; // R2
					strb_next.write_en_n = 1'b0;
					strb_next.lower_lane_sel_n = ~req_reg.lanes[0]; // R13
					strb_next.upper_lane_sel_n = ~req_reg.lanes[1]; // R13
					// float time after write enable covers the output-low case too
					cnt_next = 4'(we_float_cyc); // R7 R10
					state_next = st_strobe;
				end else begin
					cnt_next = cnt_reg - 4'd1;
				end
			end
			st_strobe: begin
				if (!oe_reg && cnt_reg <= 4'd1) begin
					oe_next = 1'b1; // R6 R7
					cnt_next = 4'(setup_cyc);
				end else if (oe_reg && cnt_reg <= 4'd1) begin
					// write enable alone terminates; data still driven across the edge
					strb_next.write_en_n = 1'b1; // R3 R4
					cnt_next = 4'(hold_cyc);
					state_next = st_hold;
				end else begin
					cnt_next = cnt_reg - 4'd1;
				end
			end
			st_hold: begin
				if (cnt_reg <= 4'd1) begin
					strb_next = idle_strobes;
					oe_next = 1'b0; // R4
					done_next = 1'b1;
					cnt_next = 4'(recover_cyc);
					state_next = st_recover;
				end else begin
					cnt_next = cnt_reg - 4'd1;
				end
			end
			st_recover: begin
				if (cnt_reg <= 4'd1) begin
					state_next = st_idle;
				end else begin
					cnt_next = cnt_reg - 4'd1;
				end
			end
			default: state_next = st_idle;
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_reg <= st_idle;
			cnt_reg <= 4'h0;
			req_reg <= '1;
			strb_reg <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
			oe_reg <= 1'b0;
			rdy_reg <= 1'b0;
			done_reg <= 1'b0;
			ret_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			req_reg <= req_next;
			strb_reg <= strb_next;
			oe_reg <= oe_next;
			rdy_reg <= rdy_next;
			done_reg <= done_next;
			ret_reg <= ret_next;
		end
	end

	assign req_ready = rdy_reg;
	assign wr_done = done_reg;
	assign retaining = ret_reg;
	assign mem_addr = req_reg.addr;
	assign mem_strobes = strb_reg;
	assign mem_data_out = req_reg.data;
	assign mem_data_oe = oe_reg;

	// write strobe low spans float wait plus data setup
	logic [3:0] wlow_reg;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wlow_reg <= 4'h0;
		end else begin
			wlow_reg <= strb_reg.write_en_n ? 4'h0 : wlow_reg + 4'd1;
		end
	end

	a_oe_high_write: assert property (@(posedge sys_clk) disable iff (reset) // R9
		!strb_reg.write_en_n |-> strb_reg.out_en_n) else $error("output enable low in write");
	a_drive_after_float: assert property (@(posedge sys_clk) disable iff (reset) // R6
		$rose(oe_reg) |-> $past(!strb_reg.write_en_n, we_float_cyc))
		else $error("data driven before float");
	a_strobes_together: assert property (@(posedge sys_clk) disable iff (reset) // R2
		$fell(strb_reg.write_en_n) |-> !strb_reg.chip_sel_n &&
		!(strb_reg.lower_lane_sel_n && strb_reg.upper_lane_sel_n))
		else $error("write started without all strobes");
	a_data_over_edge: assert property (@(posedge sys_clk) disable iff (reset) // R4
		$rose(strb_reg.write_en_n) |-> oe_reg && $stable(mem_data_out))
		else $error("data not held at write end");
	a_pulse_width: assert property (@(posedge sys_clk) disable iff (reset) // R10
		$rose(strb_reg.write_en_n) |-> wlow_reg >= pulse_cyc4)
		else $error("write pulse too short");
	a_we_ends_first: assert property (@(posedge sys_clk) disable iff (reset) // R3
		$rose(strb_reg.write_en_n) |-> !strb_reg.chip_sel_n)
		else $error("write not ended by write enable");
	a_retain_idle: assert property (@(posedge sys_clk) disable iff (reset) // R12
		ret_reg |-> strb_reg == idle_strobes && !oe_reg && &req_reg)
		else $error("inputs not parked in retention");
	a_lane_map: assert property (@(posedge sys_clk) disable iff (reset) // R13
		$fell(strb_reg.write_en_n) |-> strb_reg.lower_lane_sel_n == ~req_reg.lanes[0] &&
		strb_reg.upper_lane_sel_n == ~req_reg.lanes[1])
		else $error("lane selects wrong");
	a_float_wait: assert property (@(posedge sys_clk) disable iff (reset) // R5
		$fell(strb_reg.write_en_n) |-> !oe_reg) else $error("drove during off time");

	// pin discipline around every write and while parked
	a_cs_covers_we: assert property (@(posedge sys_clk) disable iff (reset) // R2
		!strb_reg.write_en_n |-> !strb_reg.chip_sel_n)
		else $error("write enable low without select");
	a_empty_no_strobe: assert property (@(posedge sys_clk) disable iff (reset) // R2
		$fell(strb_reg.chip_sel_n) |-> !lanes_empty(req_reg.lanes))
		else $error("select lowered with no lane");
	a_setup_before_end: assert property (@(posedge sys_clk) disable iff (reset) // R4
		$rose(strb_reg.write_en_n) |-> $past(oe_reg, setup_cyc))
		else $error("data setup short at write end");
	a_data_held_drive: assert property (@(posedge sys_clk) disable iff (reset) // R4
		oe_reg |-> $stable(mem_data_out))
		else $error("data moved while driven");
	a_addr_held_write: assert property (@(posedge sys_clk) disable iff (reset) // R4
		!strb_reg.chip_sel_n |-> $stable(mem_addr))
		else $error("address moved while selected");
	a_oe_in_write: assert property (@(posedge sys_clk) disable iff (reset) // R6
		oe_reg |-> !strb_reg.write_en_n || state_reg == st_hold)
		else $error("data driven outside write");
	a_done_released: assert property (@(posedge sys_clk) disable iff (reset) // R3
		done_reg |-> strb_reg == idle_strobes && !oe_reg)
		else $error("done before strobes released");
	a_ready_parked: assert property (@(posedge sys_clk) disable iff (reset) // R9
		rdy_reg |-> strb_reg == idle_strobes && !oe_reg && state_reg == st_idle)
		else $error("ready while pins active");
	a_retain_no_ready: assert property (@(posedge sys_clk) disable iff (reset) // R12
		ret_reg |-> !rdy_reg)
		else $error("ready during retention");
	a_retain_from_idle: assert property (@(posedge sys_clk) disable iff (reset) // R12
		$rose(ret_reg) |-> $past(state_reg) == st_idle)
		else $error("retention entered mid write");

	c_full_word: cover property (@(posedge sys_clk) $rose(oe_reg) && req_reg.lanes == 2'b11);
	c_low_byte: cover property (@(posedge sys_clk) $rose(oe_reg) && req_reg.lanes == 2'b01);
	c_retain: cover property (@(posedge sys_clk) $rose(ret_reg));
	c_done: cover property (@(posedge sys_clk) done_reg ##1 !done_reg [*2] ##1 rdy_reg);
	c_no_lanes: cover property (@(posedge sys_clk) $rose(done_reg) && lanes_empty(req_reg.lanes));
endmodule

// ---- verilog/sram_wr_pkg.sv ----
// Notes on behaviour
// R1 - memory writes during select, enable, lane overlap
// R2 - assert all three strobes before write starts
// R3 - first strobe released ends the write
// R4 - data stable around terminating edge
// R5 - memory drives until output-off interval elapses
// R6 - never drive bus while memory outputs active
// R7 - with output enable low, wait float interval
// R8 - memory drives old read data until float
// R9 - keep output enable high during writes
// R10 - lane-controlled writes meet pulse and float
// R11 - no old data if output enable raised first
// R12 - retention: hold all inputs inactive like select
// R13 - lower lane bits 0-7, upper lane bits 8-15
package sram_wr_pkg;
	localparam int addr_w = 21;
	localparam int data_w = 16;
	localparam int clk_period_ns = 8;
	// timing figures in ns
	localparam int output_off_float_time = 5;
	localparam int write_to_float_time = 4;
	localparam int write_pulse_width = 10;
	localparam int addr_setup_time = 0;
	localparam int data_setup_ns = 6;
	localparam int data_hold_ns = 0;
	localparam int write_cycle_ns = 10;
	// least times round up, never below one cycle
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + clk_period_ns - 1) / clk_period_ns;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int oe_off_cyc = cyc_up(output_off_float_time);
	localparam int we_float_cyc = cyc_up(write_to_float_time);
	localparam int pulse_cyc = cyc_up(write_pulse_width);
	localparam int setup_cyc = cyc_up(data_setup_ns);
	localparam int hold_cyc = cyc_up(data_hold_ns);
	localparam int recover_cyc = cyc_up(write_cycle_ns);
	localparam logic [3:0] pulse_cyc4 = 4'(pulse_cyc);

	typedef struct packed {
		logic [addr_w-1:0] addr;
		logic [data_w-1:0] data;
		logic [1:0] lanes;
	} wr_req_s;

	typedef struct packed {
		logic chip_sel_n;
		logic write_en_n;
		logic out_en_n;
		logic upper_lane_sel_n;
		logic lower_lane_sel_n;
	} strobes_s;

	typedef enum logic [2:0] {st_idle, st_float, st_strobe, st_hold, st_recover} wr_state_e;
endpackage

// ---- sim/sram_dev_model.sv ----
`timescale 1ns/100ps
module sram_dev_model (
	// memory pins
	input wire logic [sram_wr_pkg::addr_w-1:0] addr,
	input wire sram_wr_pkg::strobes_s st,
	input wire logic [sram_wr_pkg::data_w-1:0] bus,
	// read drive
	output logic rd_en,
	output logic [sram_wr_pkg::data_w-1:0] rd_q
);
	import sram_wr_pkg::*;
	logic [15:0] mem [0:15];
	logic [15:0] d_l;
	logic [1:0] ln_l;
	logic wr;
	// write window is the overlap of all three strobes
	assign wr = !st.chip_sel_n && !st.write_en_n && !(st.upper_lane_sel_n && st.lower_lane_sel_n);
	always_latch begin
		if (wr) begin
			d_l = bus;
			ln_l = ~{st.upper_lane_sel_n, st.lower_lane_sel_n};
		end
	end
	// commit on whichever strobe ends the window, per lane
	always @(negedge wr) begin
		if (ln_l[0]) mem[addr[3:0]][7:0] = d_l[7:0];
		if (ln_l[1]) mem[addr[3:0]][15:8] = d_l[15:8];
	end
	// simplest turn-off: float at once when writing or output enable high
	assign rd_en = !st.chip_sel_n && st.write_en_n && !st.out_en_n;
	assign rd_q = mem[addr[3:0]];
endmodule

// ---- sim/async_sram_write_cycle_tb.sv ----
`timescale 1ns/100ps
module async_sram_write_cycle_tb;
	import sram_wr_pkg::*;
	logic sys_clk = 0, reset = 1, req_valid = 0, retain = 0;
	wr_req_s req = '0;
	logic req_ready, wr_done, retaining, doe, rd_en, oe_prev = 0, we_prev = 1;
	logic [20:0] mem_addr;
	strobes_s strb;
	logic [15:0] dout, rd_q, bus;
	int error_cnt = 0, comparisons = 0, wl = 0;
	// floating bus shows the inverse so stale data never passes
	assign bus = doe ? dout : (rd_en ? rd_q : ~dout);
	always #4 sys_clk = ~sys_clk;
	sram_write_host dut (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .wr_done(wr_done), .retain(retain), .retaining(retaining),
		.mem_addr(mem_addr), .mem_strobes(strb), .mem_data_out(dout), .mem_data_oe(doe));
	sram_dev_model mem_dev (.addr(mem_addr), .st(strb), .bus(bus), .rd_en(rd_en), .rd_q(rd_q));
	task automatic check(input logic [20:0] seen, input logic [20:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wait_ready;
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge sys_clk);
			n++;
		end
		check(n < 50, 1);
	endtask
	task automatic wr(input logic [20:0] a, input logic [15:0] d, input logic [1:0] l,
		input logic [15:0] exp);
		int n;
		n = 0;
		req = '{a, d, l};
		req_valid = 1;
		wait_ready();
		@(negedge sys_clk);
		req_valid = 0;
		while (wr_done !== 1'b1 && n < 50) begin
			@(negedge sys_clk);
			n++;
		end
		check(n < 50, 1);
		check(mem_dev.mem[a[3:0]], exp);
		check(mem_addr, a);
	endtask
	task automatic retention;
		int n;
		n = 0;
		retain = 1;
		while (retaining !== 1'b1 && n < 50) begin
			@(negedge sys_clk);
			n++;
		end
		check(n < 50, 1);
		check(strb, 5'h1f);
		check(req_ready, 0);
		check(mem_addr, 21'h1fffff);
		check(dout, 16'hffff);
		check(doe, 0);
		retain = 0;
		wait_ready();
	endtask
	// pin watcher: 2 cycles of write pulse (10 ns), 1 cycle of float (4 ns)
	always @(negedge sys_clk) begin
		if (!reset) begin
			if (!strb.write_en_n) wl = wl + 1;
			else if (wl > 0) begin
				check(wl >= 2, 1);
				wl = 0;
			end
			if (doe) begin
				check(strb.out_en_n, 1);
				check(rd_en, 0);
				if (!oe_prev) check(wl >= 2, 1);
			end
			if (strb.write_en_n && !we_prev) check(doe, 1);
			oe_prev = doe;
			we_prev = strb.write_en_n;
		end
	end
	initial begin
		#20000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		repeat (5) @(negedge sys_clk);
		reset = 0;
		wr(21'h12345, 16'ha5c3, 2'b11, 16'ha5c3);
		wr(21'h12345, 16'h1111, 2'b01, 16'ha511);
		wr(21'h12345, 16'h2222, 2'b10, 16'h2211);
		wr(21'h12345, 16'h3333, 2'b00, 16'h2211);
		retention();
		wr(21'h0000f, 16'h0ff0, 2'b11, 16'h0ff0);
		print_verdict();
	end
endmodule
